/* acs_consts.svh */
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// ==========================================================
// Register map
`define ACS_REF_CTRL_ADDR 8'hd1
`define ACS_REF_CTRL_RESET 3'h0

// ==========================================================
// Field positions inside the reference control byte
`define ACS_BIT_REF_BUF 0
`define ACS_BIT_BIAS 1
`define ACS_BIT_TEMP 2
`define ACS_CTRL_BITS 3
`define ACS_UNUSED_BITS 5

// ==========================================================
// Converter multiplexer: the sensor sits on its highest input
`define ACS_MUX_INPUTS 9
`define ACS_TEMP_MUX_CH 4'h8

`endif

/* acs_pkg.sv */
// ==========================================================
// Types shared by the reference control block
package acs_pkg;

    // One special-function register access from the core
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } acs_sfr_req_t;

    // The three analog enables, in register bit order
    typedef struct packed {
        logic temp_sensor_enable;
        logic analog_bias_enable;
        logic ref_buffer_enable;
    } acs_ctrl_t;

    // Read answer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } acs_sfr_rsp_t;

endpackage : acs_pkg

/* acs_enable_reg.sv */
`timescale 1ns/1ps
`include "acs_consts.svh"

// ==========================================================
// Holder of the three enables; its flops drive the analog blocks directly
module acs_enable_reg (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire acs_pkg::acs_ctrl_t wr_val,
    output acs_pkg::acs_ctrl_t ctrl_q
);
    import acs_pkg::*;

    acs_ctrl_t ctrl_d;

    // Only the three low bits exist; the rest of the byte is dropped upstream
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_en) begin
            ctrl_d = wr_val; // see [RL10]
        end
    end

    // Synchronous reset leaves every analog block off
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_q <= acs_ctrl_t'(`ACS_REF_CTRL_RESET); // see [RL10]
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

endmodule : acs_enable_reg

/* acs_ref_ctrl.sv */
`timescale 1ns/1ps
`include "acs_consts.svh"

// Contract
// [RL1] Bits 7 to 3 read zero, writes ignored
// [RL2] Bit 2 switches the temperature sensor
// [RL3] Bit 1 switches converter bias circuitry
// [RL4] Bit 0 switches bandgap and reference buffer
// [RL5] Buffer off puts reference pin in high-Z
// [RL6] Internal reference: software sets bias and buffer
// [RL7] External reference: buffer off, bias on
// [RL8] Software may clear both when converters idle
// [RL9] Sensor on top mux input, high-Z when off
// [RL10] Enables registered, reset clear, act next cycle
module acs_ref_ctrl (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire acs_pkg::acs_sfr_req_t sfr_req,
    output acs_pkg::acs_sfr_rsp_t sfr_rsp,
    output logic temp_sensor_enable,
    output logic temp_sensor_oe,
    output logic [3:0] temp_mux_channel,
    output logic analog_bias_enable,
    output logic ref_buffer_enable,
    output logic vref_oe
);
    import acs_pkg::*;

    // ==========================================================
    // Address decode
    logic hit;
    logic wr_hit;
    logic rd_hit;
    acs_ctrl_t wr_val;
    acs_ctrl_t ctrl_q;

    // The core owns the bus on this clock, so no synchronisers are needed
    always_comb begin
        hit = 1'b0;
        if (sfr_req.addr == `ACS_REF_CTRL_ADDR) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
        wr_hit = hit & sfr_req.wr;
        rd_hit = hit & sfr_req.rd;
    end

    // Upper five bits of the write byte are simply not wired in
    always_comb begin
        wr_val = '0;
        wr_val.temp_sensor_enable = sfr_req.wdata[`ACS_BIT_TEMP]; // see [RL2]
        wr_val.analog_bias_enable = sfr_req.wdata[`ACS_BIT_BIAS]; // see [RL3]
        wr_val.ref_buffer_enable = sfr_req.wdata[`ACS_BIT_REF_BUF]; // see [RL4]
    end

    // ==========================================================
    // Enable storage
    acs_enable_reg u_enable_reg (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_en(wr_hit),
        .wr_val(wr_val),
        .ctrl_q(ctrl_q)
    );

    // Level enables come straight from the storage flops
    assign temp_sensor_enable = ctrl_q.temp_sensor_enable; // see [RL2]
    assign analog_bias_enable = ctrl_q.analog_bias_enable; // see [RL3]
    assign ref_buffer_enable = ctrl_q.ref_buffer_enable; // see [RL4]

    // ==========================================================
    // Pin drive enables and sensor mux routing
    logic vref_oe_d;
    logic vref_oe_q;
    logic temp_oe_d;
    logic temp_oe_q;
    logic [3:0] temp_ch_q;

    // Drive enables follow the next register value, so they switch in step
    // with the enables and the pin is never driven by a stale buffer
    always_comb begin
        vref_oe_d = ref_buffer_enable;
        temp_oe_d = temp_sensor_enable;
        if (wr_hit) begin
            vref_oe_d = wr_val.ref_buffer_enable; // see [RL5]
            temp_oe_d = wr_val.temp_sensor_enable; // see [RL9]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            vref_oe_q <= 1'b0;
            temp_oe_q <= 1'b0;
            temp_ch_q <= `ACS_TEMP_MUX_CH;
        end else begin
            vref_oe_q <= vref_oe_d; // see [RL5]
            temp_oe_q <= temp_oe_d; // see [RL9]
            temp_ch_q <= `ACS_TEMP_MUX_CH; // see [RL9]
        end
    end

    assign vref_oe = vref_oe_q;
    assign temp_sensor_oe = temp_oe_q;
    assign temp_mux_channel = temp_ch_q;

    // ==========================================================
    // Read path
    acs_sfr_rsp_t rsp_d;
    acs_sfr_rsp_t rsp_q;

    // Data is held between reads; unmapped addresses get no answer at all,
    // leaving the core's own read mux to pick another slave
    always_comb begin
        rsp_d = rsp_q;
        rsp_d.valid = rd_hit;
        if (rd_hit) begin
            rsp_d.data = {{`ACS_UNUSED_BITS{1'b0}}, ctrl_q}; // see [RL1]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    assign sfr_rsp = rsp_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_unused_read_zero: assert property ( // see [RL1]
        rsp_q.valid |-> rsp_q.data[7:3] == 5'h00
    ) else $error("Unused control bits read back non-zero");

    a_temp_write_effect: assert property ( // see [RL2]
        wr_hit |=> temp_sensor_enable == $past(sfr_req.wdata[2])
    ) else $error("Sensor enable did not follow written bit 2");

    a_bias_write_effect: assert property ( // see [RL3]
        wr_hit |=> analog_bias_enable == $past(sfr_req.wdata[1])
    ) else $error("Bias enable did not follow written bit 1");

    a_refbuf_write_effect: assert property ( // see [RL4]
        wr_hit |=> ref_buffer_enable == $past(sfr_req.wdata[0])
    ) else $error("Buffer enable did not follow written bit 0");

    a_vref_highz_off: assert property ( // see [RL5]
        vref_oe == ref_buffer_enable
    ) else $error("Reference pin driven while buffer disabled");

    a_temp_highz_off: assert property ( // see [RL9]
        temp_sensor_oe == temp_sensor_enable && temp_mux_channel == 4'h8
    ) else $error("Sensor output drive or mux channel wrong");

    a_ctrl_hold_idle: assert property ( // see [RL10]
        !wr_hit |=> $stable(ctrl_q)
    ) else $error("Enables changed without a register write");

    a_readback_match: assert property ( // see [RL1]
        rd_hit && !wr_hit ##1 !wr_hit |-> rsp_q.valid && rsp_q.data == {5'h00, ctrl_q}
    ) else $error("Read data does not match stored enables");

    a_read_only_hit: assert property ( // see [RL10]
        rsp_q.valid |-> $past(sfr_req.rd) && $past(sfr_req.addr) == 8'hd1
    ) else $error("Read answer without a read of the register");

    // ==========================================================
    // Assertions on pin drive, read answer and reset
    a_refbuf_pin_off: assert property ( // see [RL5]
        !ref_buffer_enable |-> !vref_oe
    ) else $error("Reference pin driven while buffer enable is clear");

    a_vref_oe_write: assert property ( // see [RL5]
        wr_hit |=> vref_oe == $past(sfr_req.wdata[0])
    ) else $error("Reference pin drive did not follow written bit 0");

    a_vref_oe_hold: assert property ( // see [RL5]
        !wr_hit |=> $stable(vref_oe)
    ) else $error("Reference pin drive changed without a write");

    a_sensor_pin_off: assert property ( // see [RL9]
        !temp_sensor_enable |-> !temp_sensor_oe
    ) else $error("Sensor output driven while sensor enable is clear");

    a_sensor_oe_write: assert property ( // see [RL9]
        wr_hit |=> temp_sensor_oe == $past(sfr_req.wdata[2])
    ) else $error("Sensor output drive did not follow written bit 2");

    a_sensor_oe_hold: assert property ( // see [RL9]
        !wr_hit |=> $stable(temp_sensor_oe)
    ) else $error("Sensor output drive changed without a write");

    a_upper_write_drop: assert property ( // see [RL1]
        wr_hit |=> {temp_sensor_enable, analog_bias_enable, ref_buffer_enable} == $past(sfr_req.wdata[2:0])
    ) else $error("Enables do not equal the three low written bits");

    a_read_pulse_one: assert property ( // see [RL10]
        rd_hit |=> rsp_q.valid
    ) else $error("No read answer after a read of the register");

    a_miss_no_answer: assert property ( // see [RL10]
        !rd_hit |=> !rsp_q.valid
    ) else $error("Read answer without a read hit");

    a_read_data_hold: assert property ( // see [RL1]
        !rd_hit |=> $stable(rsp_q.data)
    ) else $error("Read data changed without a read hit");

    a_read_write_old: assert property ( // see [RL1]
        rd_hit && wr_hit |=> rsp_q.data == {5'h00, $past(ctrl_q)}
    ) else $error("Read with write did not return the old value");

    a_reset_clears: assert property ( // see [RL10]
        disable iff (1'b0) !rst_n |=> ctrl_q == 3'h0 && !vref_oe && !temp_sensor_oe && !rsp_q.valid
    ) else $error("Reset did not clear enables, pin drives and answer");

endmodule : acs_ref_ctrl

/* acs_ref_ctrl_tb.sv */
`timescale 1ns/1ps
`include "acs_consts.svh"

// ==========================================================
// Bench for the reference control register
module acs_ref_ctrl_tb;
    import acs_pkg::*;

    logic clk_sys;
    logic rst_n;
    acs_sfr_req_t sfr_req;
    acs_sfr_rsp_t sfr_rsp;
    logic temp_sensor_enable;
    logic temp_sensor_oe;
    logic [3:0] temp_mux_channel;
    logic analog_bias_enable;
    logic ref_buffer_enable;
    logic vref_oe;
    int mismatches;
    int cmp_count;

    acs_ref_ctrl u_dut (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sfr_req(sfr_req),
        .sfr_rsp(sfr_rsp),
        .temp_sensor_enable(temp_sensor_enable),
        .temp_sensor_oe(temp_sensor_oe),
        .temp_mux_channel(temp_mux_channel),
        .analog_bias_enable(analog_bias_enable),
        .ref_buffer_enable(ref_buffer_enable),
        .vref_oe(vref_oe)
    );

    // ==========================================================
    // Clock, 5 ns period
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Shared comparison and verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude;
        $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // Enables and output enables against the expected three bits
    task automatic chk_pins(input logic [2:0] e);
        chk({1'b0, temp_sensor_oe, vref_oe, 2'b0, temp_sensor_enable, analog_bias_enable, ref_buffer_enable},
            {1'b0, e[2], e[0], 2'b0, e});
        chk({4'h0, temp_mux_channel}, {4'h0, `ACS_TEMP_MUX_CH});
    endtask : chk_pins

    // ==========================================================
    // Register access: one-cycle strobes, taken at the next edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_req <= '{a, 1'b1, 1'b0, d};
        @(posedge clk_sys);
        sfr_req.wr <= 1'b0;
        #1;
    endtask : wr

    // Valid is a one-cycle pulse, so it is looked at in that cycle
    task automatic rd(input logic [7:0] a, input logic hit, input logic [7:0] exp);
        @(posedge clk_sys);
        sfr_req <= '{a, 1'b0, 1'b1, 8'h00};
        @(posedge clk_sys);
        sfr_req.rd <= 1'b0;
        #1;
        chk({7'h0, sfr_rsp.valid}, {7'h0, hit});
        if (hit) begin
            chk(sfr_rsp.data, exp);
        end
        @(posedge clk_sys);
        #1;
        chk({7'h0, sfr_rsp.valid}, 8'h00);
    endtask : rd

    // Read and write in one cycle: the answer carries the value before the write
    task automatic rdwr(input logic [7:0] d, input logic [7:0] exp);
        @(posedge clk_sys);
        sfr_req <= '{`ACS_REF_CTRL_ADDR, 1'b1, 1'b1, d};
        @(posedge clk_sys);
        sfr_req <= '{`ACS_REF_CTRL_ADDR, 1'b0, 1'b0, d};
        #1;
        chk({7'h0, sfr_rsp.valid}, 8'h01);
        chk(sfr_rsp.data, exp);
    endtask : rdwr

    // ==========================================================
    // Main sequence
    initial begin
        mismatches = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        sfr_req = '0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        chk_pins(3'h0);
        rd(`ACS_REF_CTRL_ADDR, 1'b1, 8'h00);
        // Every enable combination, upper bits set to prove they drop
        for (int i = 0; i < 8; i++) begin
            wr(`ACS_REF_CTRL_ADDR, 8'hf8 | 8'(i));
            chk_pins(3'(i));
            rd(`ACS_REF_CTRL_ADDR, 1'b1, 8'(i));
        end
        // Unmapped place: write ignored, read gives no answer
        wr(8'hd0, 8'h00);
        chk_pins(3'h7);
        rd(8'hd0, 1'b0, 8'h00);
        // Two writes, external reference then buffer and sensor only
        wr(`ACS_REF_CTRL_ADDR, 8'h02);
        chk_pins(3'h2);
        wr(`ACS_REF_CTRL_ADDR, 8'h05);
        chk_pins(3'h5);
        // Read and write together: old value answered, new value stored
        rdwr(8'h06, 8'h05);
        chk_pins(3'h6);
        // Reset in mid-run clears everything
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        chk_pins(3'h0);
        rd(`ACS_REF_CTRL_ADDR, 1'b1, 8'h00);
        conclude();
    end

    // Watchdog against a hung run
    initial begin
        #100000;
        mismatches++;
        conclude();
    end

endmodule : acs_ref_ctrl_tb
